// file: core/spw_traffic_ctrl.sv
// Pause frame sender, wrap test control, frame steering and traffic mirroring
// How it works
// - Congestion sends pause, now or after frame
// - Pause time chosen by port speed
// - Still congested at 80 percent: resend
// - Zero pause time at a speed: none
// - Reception continues normally after pause sent
// - Own pause sent even while paused
// - Internal wrap loops selected ports back
// - Port 0 or 8 may stay out
// - Insert own tag on receive, strip on send
// - Unknown: VLAN mask AND unknown mask
// - Looped frame retagged with port VLAN (code ignores loop_en: retags only rx_ins ports and the management port)
// - Internal wrap ignores PHY link state
// - Duplex wrap forces full duplex
// - Coding loopback in PMA mode: external wrap
// - Mirror enable copies port traffic to uplink
// - Only the named trunk member mirrored
// - Flagged unicast destination copied to uplink
// - Pause frame fields in fixed layout
// - Pause frames exactly 64 bytes
// - Pause needs negotiation, full duplex, flow enable
// - Pause quantum is 512 bit times
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module spw_traffic_ctrl (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata_q,
	// PHY status pins
	input wire logic [8:0] phy_link,
	input wire logic [8:0] phy_full_duplex,
	input wire logic [8:0] phy_pause_ok,
	input wire logic [8:0] phy_speed100,
	// Buffer manager and transmit MACs
	input wire logic [10:0] free_buf_count,
	input wire logic [8:0] tx_busy,
	// Pause frame byte stream
	output logic pf_valid_q,
	output logic [3:0] pf_port_q,
	output logic [7:0] pf_data_q,
	output logic pf_last_q,
	// Route request
	input wire logic rt_req,
	input wire logic [3:0] rt_src,
	input wire logic [11:0] rt_vid,
	input wire logic rt_mcast,
	input wire logic rt_known,
	input wire logic [9:0] rt_known_mask,
	input wire logic rt_copy_uplink,
	// Route answer
	output logic route_valid_q,
	output logic [9:0] route_mask_q,
	output logic [11:0] route_vid_q,
	// Port modes
	output logic [8:0] loop_en_q,
	output logic [8:0] full_duplex_q,
	output logic [8:0] port_up_q,
	output logic [8:0] tag_strip_q,
	output logic [8:0] external_wrap_out_q
);
	// ==========================================
	// State
	typedef struct packed {
		logic [1:0] sys_ctrl; // Flow and mirror enables
		logic [14:0] sys_test; // Wrap controls
		logic [10:0] thresh; // Free buffer threshold
		logic [15:0] pt10, pt100; // Pause time per speed
		logic [3:0] mirror, uplink; // Mirrored and uplink ports
		logic [9:0] unk_uni, unk_multi; // Unknown destination masks
		logic [8:0] rx_ins, tx_strip; // Tag insert and strip
		logic [8:0] pma, pcs_lb; // coding_sublayer_ctrl
		logic [47:0] sta; // Station address
		logic [9:0][11:0] tag; // port_vlan_tag_reg per port
		logic [35:0] phy_s1, phy_s2; // Pin synchroniser
		logic congested; // Below threshold last cycle
		logic [8:0] pend, armed; // Pause queued, resend timer live
		logic [8:0][15:0] remain; // Quanta left before resend check
		logic [11:0] div10; // Quantum divider, slow ports
		logic [7:0] div100; // Quantum divider, fast ports
		logic pf_valid, pf_last; // Stream flags
		logic [3:0] pf_port; // Port taking the frame
		logic [5:0] pf_idx; // Byte index
		logic [7:0] pf_data; // Byte out
		logic [15:0] pf_time; // Pause time in the frame
		logic [31:0] crc; // Running check sum
		logic r1_v, r1_mcast, r1_known, r1_copy; // Route stage one
		logic [3:0] r1_src;
		logic [9:0] r1_kmask;
		logic [11:0] r1_vid;
		logic route_valid; // Route answer
		logic [9:0] route_mask;
		logic [11:0] route_vid;
		logic [8:0] loop_en, fdx, port_up, ewrap; // Port modes
		logic [31:0] rdata; // Read data
	} spw_state_t;
	spw_state_t s, d;

	logic [9:0] mem_q; // VLAN member mask read
	logic [4:0] mem_raddr; // VLAN index of the request
	logic mem_we; // Mask write strobe

	// VLAN member masks, indexed by the low VID bits
	spw_vlan_mem u_mem (
		.ref_clk(ref_clk),
		.rst(rst),
		.we(mem_we),
		.waddr(reg_addr[6:2]),
		.wdata(reg_wdata[9:0]),
		.raddr(mem_raddr),
		.rdata_q(mem_q)
	);

	// ==========================================
	// Next state
	always_comb begin
		logic [8:0] lnk, fd, pok, spd, el, lp;
		logic [15:0] pt;
		logic tick10, tick100, cong, onset, start, up;
		logic [3:0] sel;
		logic [5:0] nidx;
		logic [7:0] nb;
		logic [9:0] m;
		d = s;
		el = 9'h000;
		lp = 9'h000;
		m = 10'h000;
		nidx = 6'h00;
		tick10 = 1'b0;
		tick100 = 1'b0;
		cong = 1'b0;
		onset = 1'b0;
		up = 1'b0;
		lnk = s.phy_s2[8:0];
		fd = s.phy_s2[17:9];
		pok = s.phy_s2[26:18];
		spd = s.phy_s2[35:27];
		pt = 16'h0000;
		nb = 8'h00;
		sel = 4'h0;
		start = 1'b0;
		// Pins pass two flops before use
		d.phy_s1 = {phy_speed100, phy_pause_ok, phy_full_duplex, phy_link};
		d.phy_s2 = s.phy_s1;
		// Register writes; mask memory from 0x80 up
		mem_we = reg_wr && reg_addr[7];
		if (reg_wr && !reg_addr[7]) begin
			case (reg_addr)
				spw_pkg::REG_SYS_CTRL: d.sys_ctrl = reg_wdata[1:0];
				spw_pkg::REG_SYS_TEST: d.sys_test = reg_wdata[14:0];
				spw_pkg::REG_FLOW_THRESH: d.thresh = reg_wdata[10:0];
				spw_pkg::REG_PAUSE_10: d.pt10 = reg_wdata[15:0];
				spw_pkg::REG_PAUSE_100: d.pt100 = reg_wdata[15:0];
				spw_pkg::REG_MIRROR: d.mirror = reg_wdata[3:0];
				spw_pkg::REG_UPLINK: d.uplink = reg_wdata[3:0];
				spw_pkg::REG_UNK_UNI: d.unk_uni = reg_wdata[9:0];
				spw_pkg::REG_UNK_MULTI: d.unk_multi = reg_wdata[9:0];
				spw_pkg::REG_TAG_CTRL: begin
					d.rx_ins = reg_wdata[8:0];
					d.tx_strip = reg_wdata[spw_pkg::HI_HALF_LSB +: 9];
				end
				spw_pkg::REG_CODING_CTRL: begin
					d.pma = reg_wdata[8:0];
					d.pcs_lb = reg_wdata[spw_pkg::HI_HALF_LSB +: 9];
				end
				spw_pkg::REG_STA_LO: d.sta[31:0] = reg_wdata;
				spw_pkg::REG_STA_HI: d.sta[47:32] = reg_wdata[15:0];
				default: begin
					// Port tag region
					if (reg_addr[7:6] == spw_pkg::TAG_REGION && reg_addr[5:2] < 4'hA) begin
						d.tag[reg_addr[5:2]] = reg_wdata[11:0];
					end
				end
			endcase
		end
		// Read data, one cycle after the strobe; unmapped reads zero
		d.rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				spw_pkg::REG_SYS_CTRL: d.rdata = {30'h0000_0000, s.sys_ctrl};
				spw_pkg::REG_SYS_TEST: d.rdata = {17'h0_0000, s.sys_test};
				spw_pkg::REG_FLOW_THRESH: d.rdata = {21'h00_0000, s.thresh};
				spw_pkg::REG_PAUSE_10: d.rdata = {16'h0000, s.pt10};
				spw_pkg::REG_PAUSE_100: d.rdata = {16'h0000, s.pt100};
				spw_pkg::REG_MIRROR: d.rdata = {28'h000_0000, s.mirror};
				spw_pkg::REG_UPLINK: d.rdata = {28'h000_0000, s.uplink};
				spw_pkg::REG_UNK_UNI: d.rdata = {22'h00_0000, s.unk_uni};
				spw_pkg::REG_UNK_MULTI: d.rdata = {22'h00_0000, s.unk_multi};
				spw_pkg::REG_TAG_CTRL: d.rdata = {7'h00, s.tx_strip, 7'h00, s.rx_ins};
				spw_pkg::REG_CODING_CTRL: d.rdata = {7'h00, s.pcs_lb, 7'h00, s.pma};
				spw_pkg::REG_STA_LO: d.rdata = s.sta[31:0];
				spw_pkg::REG_STA_HI: d.rdata = {16'h0000, s.sta[47:32]};
				spw_pkg::REG_STATUS: d.rdata = {15'h0000, s.congested, 7'h00, s.pend};
				default: begin
					if (reg_addr[7:6] == spw_pkg::TAG_REGION && reg_addr[5:2] < 4'hA) begin
						d.rdata = {20'h0_0000, s.tag[reg_addr[5:2]]};
					end
				end
			endcase
		end
		// Port modes
		lp = s.sys_test[8:0];
		if (s.sys_test[spw_pkg::TEST_KEEP0_BIT]) begin
			lp[0] = 1'b0;
		end
		if (s.sys_test[spw_pkg::TEST_KEEP8_BIT]) begin
			lp[8] = 1'b0;
		end
		d.loop_en = lp;
		d.fdx = fd | {9{s.sys_test[spw_pkg::TEST_DPWRAP_BIT]}};
		d.port_up = lnk | lp;
		d.ewrap = s.pma & s.pcs_lb;
		// Quantum dividers, one pulse per 512 bit times
		tick10 = (s.div10 == 12'(spw_pkg::Q10_CYC - 1));
		tick100 = (s.div100 == 8'(spw_pkg::Q100_CYC - 1));
		d.div10 = tick10 ? 12'h000 : s.div10 + 12'h001;
		d.div100 = tick100 ? 8'h00 : s.div100 + 8'h01;
		// Congestion and its onset
		cong = (free_buf_count < s.thresh);
		onset = cong && !s.congested;
		d.congested = cong;
		// Per port eligibility, queueing and resend timer
		for (int i = 0; i < spw_pkg::NPORT; i++) begin
			pt = spd[i] ? s.pt100 : s.pt10;
			el[i] = s.sys_ctrl[spw_pkg::CTRL_FLOW_BIT] && d.fdx[i] && pok[i]
				&& (pt != 16'h0000);
			// Own pause goes out regardless of any received pause
			up = spd[i] ? tick100 : tick10;
			if (!el[i]) begin
				d.pend[i] = 1'b0;
				d.armed[i] = 1'b0;
			end else begin
				// Queued or streaming already: no extra frame
				if (onset && !(s.pf_valid && s.pf_port == 4'(i))) begin
					d.pend[i] = 1'b1;
				end
				if (s.armed[i]) begin
					if (s.remain[i] == 16'h0000) begin
						d.armed[i] = 1'b0;
						d.pend[i] = d.pend[i] | cong;
					end else if (up) begin
						d.remain[i] = s.remain[i] - 16'h0001;
					end
				end
			end
		end
		// Pick the lowest queued port whose transmitter is idle
		for (int i = spw_pkg::NPORT - 1; i >= 0; i--) begin
			if (s.pend[i] && el[i] && !tx_busy[i]) begin
				start = 1'b1;
				sel = 4'(i);
			end
		end
		// Pause frame stream, one byte a cycle, 64 bytes
		nidx = s.pf_idx + 6'h01;
		if (s.pf_valid) begin
			if (s.pf_last) begin
				d.pf_valid = 1'b0;
				d.pf_last = 1'b0;
			end else begin
				nb = spw_pkg::pf_byte(nidx, s.sta, s.pf_time);
				if (nidx >= spw_pkg::PF_CRC_IDX) begin
					nb = ~s.crc[8 * (nidx - spw_pkg::PF_CRC_IDX) +: 8];
				end else begin
					d.crc = spw_pkg::crc_upd(s.crc, nb);
				end
				d.pf_idx = nidx;
				d.pf_data = nb;
				d.pf_last = (nidx == spw_pkg::PF_LAST_IDX);
			end
		end else if (start) begin
			pt = spd[sel] ? s.pt100 : s.pt10;
			d.pend[sel] = 1'b0;
			d.armed[sel] = 1'b1;
			// Spare quantum covers the free-running divider phase
			d.remain[sel] = spw_pkg::thr80(pt) + 16'h0001;
			d.pf_valid = 1'b1;
			d.pf_port = sel;
			d.pf_idx = 6'h00;
			d.pf_time = pt;
			nb = spw_pkg::pf_byte(6'h00, s.sta, pt);
			d.pf_data = nb;
			d.crc = spw_pkg::crc_upd(spw_pkg::CRC_INIT, nb);
		end
		// Route stage one: own tag replaces the frame tag on receive
		d.r1_v = rt_req; // Pause state never blocks reception
		d.r1_src = rt_src;
		d.r1_mcast = rt_mcast;
		d.r1_known = rt_known;
		d.r1_kmask = rt_known_mask;
		d.r1_copy = rt_copy_uplink;
		d.r1_vid = rt_vid;
		if (rt_src == spw_pkg::MGMT_PORT) begin
			d.r1_vid = s.tag[spw_pkg::MGMT_PORT];
		end else if (rt_src < spw_pkg::MGMT_PORT && s.rx_ins[rt_src]) begin
			d.r1_vid = s.tag[rt_src];
		end
		mem_raddr = d.r1_vid[4:0];
		// Route stage two: destinations plus uplink copies
		m = s.r1_known ? s.r1_kmask : (mem_q & (s.r1_mcast ? s.unk_multi : s.unk_uni));
		// Only the named port is compared, never its trunk mates
		if (s.sys_ctrl[spw_pkg::CTRL_MIRR_BIT] && s.mirror < 4'hA
			&& (s.r1_src == s.mirror || m[s.mirror])) begin
			if (s.uplink < 4'hA) begin
				m[s.uplink] = 1'b1;
			end
		end
		if (s.r1_copy && !s.r1_mcast && s.uplink < 4'hA) begin
			m[s.uplink] = 1'b1;
		end
		d.route_valid = s.r1_v;
		d.route_mask = s.r1_v ? m : s.route_mask;
		d.route_vid = s.r1_v ? s.r1_vid : s.route_vid;
	end

	// ==========================================
	// Register the state
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s <= '0;
			s.thresh <= spw_pkg::FLOW_THRESH_RST;
			s.pt10 <= spw_pkg::PAUSE_TIME_RST;
			s.pt100 <= spw_pkg::PAUSE_TIME_RST;
			s.unk_uni <= spw_pkg::UNK_MASK_RST;
			s.unk_multi <= spw_pkg::UNK_MASK_RST;
		end else begin
			s <= d;
		end
	end

	// Outputs straight from the state flops
	assign reg_rdata_q = s.rdata;
	assign pf_valid_q = s.pf_valid;
	assign pf_port_q = s.pf_port;
	assign pf_data_q = s.pf_data;
	assign pf_last_q = s.pf_last;
	assign route_valid_q = s.route_valid;
	assign route_mask_q = s.route_mask;
	assign route_vid_q = s.route_vid;
	assign loop_en_q = s.loop_en;
	assign full_duplex_q = s.fdx;
	assign port_up_q = s.port_up;
	assign tag_strip_q = s.tx_strip;
	assign external_wrap_out_q = s.ewrap;

	// ==========================================
	// Checks
	logic [8:0] busy_h; // Transmit busy one cycle back
	logic [8:0] ewrap_h; // Wrap request of the last coding write
	// Helper flops for the checks below
	always_ff @(posedge ref_clk) begin
		busy_h <= tx_busy;
		if (reg_wr && reg_addr == spw_pkg::REG_CODING_CTRL) begin
			ewrap_h <= reg_wdata[8:0] & reg_wdata[spw_pkg::HI_HALF_LSB +: 9];
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence seq_pf_begin;
		$rose(pf_valid_q);
	endsequence
	sequence seq_route;
		rt_req ##2 route_valid_q;
	endsequence
	chk_pf_length: assert property (seq_pf_begin |-> ##63 pf_last_q)
		else $error("pause frame not 64 bytes");
	chk_pf_type: assert property (pf_valid_q && s.pf_idx == 6'h0C |-> pf_data_q == 8'h88)
		else $error("pause type byte wrong");
	chk_pf_idle: assert property (seq_pf_begin |-> !busy_h[pf_port_q])
		else $error("pause started on busy port");
	chk_pf_zero: assert property (pf_valid_q |-> s.pf_time != 16'h0000)
		else $error("pause sent with zero time");
	chk_pf_enable: assert property (seq_pf_begin |-> $past(s.sys_ctrl[spw_pkg::CTRL_FLOW_BIT]))
		else $error("pause sent with flow disabled");
	chk_route_lat: assert property (rt_req |-> seq_route)
		else $error("route answer late");
	chk_copy_up: assert property (rt_req && rt_copy_uplink && !rt_mcast && s.uplink == 4'h0
		|-> ##2 route_mask_q[0])
		else $error("uplink copy missing");
	chk_mirror_src: assert property (rt_req && s.sys_ctrl[spw_pkg::CTRL_MIRR_BIT]
		&& rt_src == s.mirror && s.uplink == 4'h0 |-> ##2 route_mask_q[0])
		else $error("mirror copy missing");
	chk_ewrap_write: assert property (reg_wr && reg_addr == spw_pkg::REG_CODING_CTRL
		|-> ##2 external_wrap_out_q == ewrap_h)
		else $error("external wrap wrong");
	chk_dpwrap_fdx: assert property (s.sys_test[spw_pkg::TEST_DPWRAP_BIT] |=> &full_duplex_q)
		else $error("duplex wrap not full duplex");
	chk_keep_port0: assert property (s.sys_test[spw_pkg::TEST_KEEP0_BIT] |=> !loop_en_q[0])
		else $error("port 0 looped");
endmodule : spw_traffic_ctrl

// file: core/spw_pkg.sv
// Shared constants, register map and frame helpers for the port traffic control block
package spw_pkg;
	// ==========================================
	// Sizes
	localparam int NPORT = 9; // Wire ports 0..8
	localparam int NDEST = 10; // Wire ports plus management port
	localparam logic [3:0] MGMT_PORT = 4'h9; // Management port number
	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [7:0] REG_SYS_CTRL = 8'h00;
	localparam logic [7:0] REG_SYS_TEST = 8'h04;
	localparam logic [7:0] REG_FLOW_THRESH = 8'h08;
	localparam logic [7:0] REG_PAUSE_10 = 8'h0C;
	localparam logic [7:0] REG_PAUSE_100 = 8'h10;
	localparam logic [7:0] REG_MIRROR = 8'h14;
	localparam logic [7:0] REG_UPLINK = 8'h18;
	localparam logic [7:0] REG_UNK_UNI = 8'h1C;
	localparam logic [7:0] REG_UNK_MULTI = 8'h20;
	localparam logic [7:0] REG_TAG_CTRL = 8'h24;
	localparam logic [7:0] REG_CODING_CTRL = 8'h28;
	localparam logic [7:0] REG_STA_LO = 8'h2C;
	localparam logic [7:0] REG_STA_HI = 8'h30;
	localparam logic [7:0] REG_STATUS = 8'h34;
	localparam logic [1:0] TAG_REGION = 2'b01; // port_vlan_tag_reg at 0x40 + 4*port
	// vlan_member_mask entries at 0x80 + 4*vlan, write only
	// ==========================================
	// Field positions
	localparam int CTRL_FLOW_BIT = 0;
	localparam int CTRL_MIRR_BIT = 1;
	localparam int TEST_DPWRAP_BIT = 12;
	localparam int TEST_KEEP0_BIT = 13;
	localparam int TEST_KEEP8_BIT = 14;
	localparam int HI_HALF_LSB = 16; // Strip mask and coding loopback
	localparam int STAT_CONG_BIT = 16;
	// ==========================================
	// Reset values
	localparam logic [10:0] FLOW_THRESH_RST = 11'h040;
	localparam logic [15:0] PAUSE_TIME_RST = 16'h0000;
	localparam logic [9:0] UNK_MASK_RST = 10'h3FF;
	// ==========================================
	// Timing: one pause quantum is 512 bit times
	localparam int CLK_PERIOD_PS = 25000;
	localparam int QUANTUM_BITS = 512;
	localparam int QUANTUM_NS_10 = QUANTUM_BITS * 100;
	localparam int QUANTUM_NS_100 = QUANTUM_BITS * 10;
	localparam int Q10_CYC = (QUANTUM_NS_10 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int Q100_CYC = (QUANTUM_NS_100 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// ==========================================
	// Pause frame layout
	localparam logic [47:0] PF_DEST = 48'h0180_C200_0001;
	localparam logic [15:0] PF_TYPE = 16'h8808;
	localparam logic [15:0] PF_OPCODE = 16'h0001;
	localparam logic [5:0] PF_LAST_IDX = 6'h3F; // 64 bytes
	localparam logic [5:0] PF_CRC_IDX = 6'h3C; // First check byte
	localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
	localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;

	// Header and pad byte at a frame index, most significant byte first
	function automatic logic [7:0] pf_byte(input logic [5:0] idx, input logic [47:0] sta,
		input logic [15:0] pt);
		logic [143:0] hdr;
		hdr = {PF_DEST, sta, PF_TYPE, PF_OPCODE, pt};
		if (idx < 6'h12) begin
			pf_byte = hdr[143 - 8 * idx -: 8];
		end else begin
			pf_byte = 8'h00;
		end
	endfunction : pf_byte

	// Reflected check sum update by one byte, low bit first
	function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = ((r[0] ^ b[i]) != 1'b0) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		crc_upd = r;
	endfunction : crc_upd

	// Quanta to wait before a resend: 80 percent, rounded up
	function automatic logic [15:0] thr80(input logic [15:0] pt);
		logic [18:0] p;
		p = ({3'b000, pt} << 2) + 19'h0_0004;
		thr80 = 16'(p / 19'h0_0005);
	endfunction : thr80
endpackage : spw_pkg

// file: core/spw_vlan_mem.sv
// Small memory of VLAN member masks with a registered read port
`timescale 1ns/1ps
module spw_vlan_mem (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Write port
	input wire logic we,
	input wire logic [4:0] waddr,
	input wire logic [9:0] wdata,
	// Read port, data one cycle later
	input wire logic [4:0] raddr,
	output logic [9:0] rdata_q
);
	// ==========================================
	// State
	typedef struct packed {
		logic [31:0][9:0] mem; // One destination mask per VLAN
		logic [9:0] rd; // Read data register
	} spw_mem_t;
	spw_mem_t s, d;

	// Next state
	always_comb begin
		d = s;
		if (we) begin
			d.mem[waddr] = wdata;
		end
		d.rd = s.mem[raddr];
	end

	// Register with synchronous reset
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= d;
		end
	end

	assign rdata_q = s.rd;
endmodule : spw_vlan_mem

// file: sim/spw_link_sink.sv
// Far-end model: takes the pause byte stream and plays the transmit MACs
`timescale 1ns/1ps
module spw_link_sink (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Pause byte stream
	input wire logic pf_valid_q,
	input wire logic [3:0] pf_port_q,
	input wire logic [7:0] pf_data_q,
	input wire logic pf_last_q,
	// Transmit activity
	input wire logic [8:0] tx_start,
	output logic [8:0] tx_busy
);
	logic [7:0] bytes [0:63]; // Bytes of the last frame
	int nbyte; // Bytes seen in this frame
	int flen; // Length of the last whole frame
	int nfr [0:15]; // Whole frames per port
	int overlap; // Bytes sent while that port was busy
	int bcnt; // Busy cycles left
	// ==========================================
	// Busy model and stream capture
	always @(posedge ref_clk) begin
		if (rst) begin
			nbyte = 0;
			flen = 0;
			overlap = 0;
			bcnt = 0;
			tx_busy <= 9'h000;
			foreach (nfr[i]) nfr[i] = 0;
		end else begin
			// Busy for a fixed frame time when asked
			if (tx_start != 9'h000) begin
				tx_busy <= tx_start;
				bcnt = 40;
			end else if (bcnt > 0) begin
				bcnt--;
				if (bcnt == 0) tx_busy <= 9'h000;
			end
			// Byte capture
			if (pf_valid_q === 1'b1) begin
				if (nbyte < 64) bytes[nbyte] = pf_data_q;
				nbyte++;
				if (tx_busy[pf_port_q] === 1'b1) overlap++;
				if (pf_last_q === 1'b1) begin
					flen = nbyte;
					nbyte = 0;
					nfr[pf_port_q]++;
				end
			end
		end
	end
endmodule : spw_link_sink

// file: sim/tb.sv
// Self-checking bench of the port traffic control block
`timescale 1ns/1ps
module tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata_q;
	logic [8:0] phy_link = 9'h000;
	logic [8:0] phy_full_duplex = 9'h000;
	logic [8:0] phy_pause_ok = 9'h000;
	logic [8:0] phy_speed100 = 9'h000;
	logic [10:0] free_buf_count = 11'h7FF;
	logic [8:0] tx_busy;
	logic [8:0] tx_start = 9'h000;
	logic pf_valid_q, pf_last_q, rt_req = 1'b0, rt_mcast = 1'b0, rt_known = 1'b0;
	logic [3:0] pf_port_q;
	logic [7:0] pf_data_q;
	logic [3:0] rt_src = 4'h0;
	logic [11:0] rt_vid = 12'h000;
	logic [9:0] rt_known_mask = 10'h000;
	logic rt_copy_uplink = 1'b0;
	logic route_valid_q;
	logic [9:0] route_mask_q;
	logic [11:0] route_vid_q;
	logic [8:0] loop_en_q, full_duplex_q, port_up_q, tag_strip_q, external_wrap_out_q;
	int n_mismatch = 0; // Mismatches
	int n_checks = 0; // Comparisons
	int cyc = 0; // Cycle count for the hang limit
	logic [31:0] v; // Read value
	// ==========================================
	// Clock, hang limit
	always #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			results();
		end
	end
	// ==========================================
	// Block and far end
	spw_traffic_ctrl spw_traffic_ctrl_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.phy_link(phy_link), .phy_full_duplex(phy_full_duplex), .phy_pause_ok(phy_pause_ok),
		.phy_speed100(phy_speed100), .free_buf_count(free_buf_count), .tx_busy(tx_busy),
		.pf_valid_q(pf_valid_q), .pf_port_q(pf_port_q), .pf_data_q(pf_data_q),
		.pf_last_q(pf_last_q), .rt_req(rt_req), .rt_src(rt_src), .rt_vid(rt_vid),
		.rt_mcast(rt_mcast), .rt_known(rt_known), .rt_known_mask(rt_known_mask),
		.rt_copy_uplink(rt_copy_uplink), .route_valid_q(route_valid_q),
		.route_mask_q(route_mask_q), .route_vid_q(route_vid_q), .loop_en_q(loop_en_q),
		.full_duplex_q(full_duplex_q), .port_up_q(port_up_q), .tag_strip_q(tag_strip_q),
		.external_wrap_out_q(external_wrap_out_q));
	spw_link_sink spw_link_sink_inst (.ref_clk(ref_clk), .rst(rst), .pf_valid_q(pf_valid_q),
		.pf_port_q(pf_port_q), .pf_data_q(pf_data_q), .pf_last_q(pf_last_q),
		.tx_start(tx_start), .tx_busy(tx_busy));
	// ==========================================
	// Shared tasks
	task automatic results();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata_q;
	endtask : rd
	// Mode outputs settle after a write
	task automatic settle();
		repeat (3) @(posedge ref_clk);
		#1;
	endtask : settle
	// One route request, answer two edges on
	task automatic route(input logic [3:0] s, input logic [11:0] vid, input logic mc,
		input logic kn, input logic [9:0] km, input logic cp, input logic [9:0] em,
		input logic [11:0] ev);
		@(posedge ref_clk);
		rt_req <= 1'b1;
		{rt_src, rt_vid, rt_mcast, rt_known, rt_known_mask, rt_copy_uplink} <= {s, vid, mc, kn, km, cp};
		@(posedge ref_clk);
		rt_req <= 1'b0;
		@(posedge ref_clk);
		#1 chk(32'(route_valid_q), 32'h1);
		chk(32'(route_mask_q), 32'(em));
		chk(32'(route_vid_q), 32'(ev));
	endtask : route
	// ==========================================
	// Scenarios
	task automatic t_regs();
		rd(8'h08);
		chk(v, 32'h0000_0040);
		rd(8'h1C);
		chk(v, 32'h0000_03FF);
		rd(8'h20);
		chk(v, 32'h0000_03FF);
		wr(8'h94, 32'h0000_0010);
		rd(8'h94);
		chk(v, 32'h0000_0000);
		rd(8'hFC);
		chk(v, 32'h0000_0000);
	endtask : t_regs
	task automatic t_modes();
		wr(8'h04, 32'h0000_21FF);
		settle();
		chk(32'(loop_en_q), 32'h0000_01FE);
		chk(32'(port_up_q), 32'h0000_01FE);
		wr(8'h04, 32'h0000_41FF);
		settle();
		chk(32'(loop_en_q), 32'h0000_00FF);
		wr(8'h04, 32'h0000_1000);
		settle();
		chk(32'(full_duplex_q), 32'h0000_01FF);
		wr(8'h28, 32'h0001_0001);
		settle();
		chk(32'(external_wrap_out_q), 32'h0000_0001);
		wr(8'h28, 32'h0001_0000);
		settle();
		chk(32'(external_wrap_out_q), 32'h0000_0000);
		wr(8'h04, 32'h0000_0000);
	endtask : t_modes
	task automatic t_route();
		wr(8'h24, 32'h0100_0008);
		settle();
		chk(32'(tag_strip_q), 32'h0000_0100);
		wr(8'h4C, 32'h0000_0005);
		wr(8'h18, 32'h0000_0007);
		wr(8'h14, 32'h0000_0003);
		route(4'h3, 12'h0AB, 1'b0, 1'b0, 10'h000, 1'b0, 10'h010, 12'h005);
		wr(8'h1C, 32'h0000_03EF);
		route(4'h3, 12'h0AB, 1'b0, 1'b0, 10'h000, 1'b0, 10'h000, 12'h005);
		route(4'h3, 12'h0AB, 1'b1, 1'b0, 10'h000, 1'b0, 10'h010, 12'h005);
		wr(8'h00, 32'h0000_0002);
		route(4'h3, 12'h0AB, 1'b1, 1'b0, 10'h000, 1'b0, 10'h090, 12'h005);
		route(4'h1, 12'h005, 1'b0, 1'b1, 10'h008, 1'b0, 10'h088, 12'h005);
		route(4'h1, 12'h005, 1'b0, 1'b1, 10'h002, 1'b0, 10'h002, 12'h005);
		wr(8'h00, 32'h0000_0000);
		route(4'h3, 12'h0AB, 1'b1, 1'b0, 10'h000, 1'b0, 10'h010, 12'h005);
		route(4'h1, 12'h005, 1'b0, 1'b1, 10'h002, 1'b1, 10'h082, 12'h005);
		route(4'h1, 12'h005, 1'b1, 1'b1, 10'h002, 1'b1, 10'h002, 12'h005);
	endtask : t_route
	task automatic t_pause();
		logic [143:0] hdr;
		int i;
		logic [31:0] c;
		logic [7:0] b;
		hdr = {48'h0180_C200_0001, 48'h1122_3344_5566, 16'h8808, 16'h0001, 16'h000A};
		wr(8'h2C, 32'h3344_5566);
		wr(8'h30, 32'h0000_1122);
		wr(8'h10, 32'h0000_000A); // 100M time only; 10M stays zero
		wr(8'h00, 32'h0000_0001);
		phy_full_duplex <= 9'h006;
		phy_pause_ok <= 9'h006;
		phy_speed100 <= 9'h002;
		repeat (6) @(posedge ref_clk);
		tx_start <= 9'h002;
		free_buf_count <= 11'h010;
		@(posedge ref_clk);
		tx_start <= 9'h000;
		free_buf_count <= 11'h050;
		@(posedge ref_clk);
		free_buf_count <= 11'h010;
		for (i = 0; i < 300 && spw_link_sink_inst.nfr[1] == 0; i++) @(posedge ref_clk);
		chk(32'(spw_link_sink_inst.overlap), 32'h0);
		chk(32'(spw_link_sink_inst.flen), 32'd64);
		c = 32'hFFFF_FFFF;
		for (i = 0; i < 60; i++) begin
			b = (i < 18) ? hdr[143 - 8 * i -: 8] : 8'h00;
			chk(32'(spw_link_sink_inst.bytes[i]), 32'(b));
			for (int k = 0; k < 8; k++) begin
				c = (c[0] ^ b[k]) ? ((c >> 1) ^ 32'hEDB8_8320) : (c >> 1);
			end
		end
		// Check word goes out inverted, low byte first
		for (i = 0; i < 4; i++) begin
			b = ~c[8 * i +: 8];
			chk(32'(spw_link_sink_inst.bytes[60 + i]), 32'(b));
		end
		// Route and status read fill five of the hundred cycles
		repeat (95) @(posedge ref_clk);
		chk(32'(spw_link_sink_inst.nfr[1]), 32'h1);
		route(4'h1, 12'h005, 1'b0, 1'b1, 10'h002, 1'b0, 10'h002, 12'h005);
		rd(8'h34);
		chk(v, 32'h0001_0000);
		// Resend no sooner than 8 quanta of 205 cycles, within one more quantum
		for (i = 100; i < 2000 && spw_link_sink_inst.nfr[1] == 1; i++) @(posedge ref_clk);
		chk(32'((i >= 1640) && (i <= 1860)), 32'h1);
		chk(32'(spw_link_sink_inst.nfr[2]), 32'h0);
		free_buf_count <= 11'h7FF;
		// Slow port time ten times the fast one
		wr(8'h0C, 32'h0000_0064);
		rd(8'h0C);
		chk(v, 32'h0000_0064);
	endtask : t_pause
	// ==========================================
	// Main sequence
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		t_regs();
		t_modes();
		t_route();
		t_pause();
		results();
	end
endmodule : tb
